// ### rtl/arb_consts.svh
// Named constants for the backplane serial arbitration block.
// Assumes inclusion by bare name from the package and design files.
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH
// Reference period of mclk in ns; the documented rates are 98.304 MHz or 49.152 MHz.
`define REF_CLK_PERIOD_NS 10
// Cycles of mclk in one arbitration or transmit bit period.
`define BIT_CYCLES        4'h8
`define BIT_LAST          4'h7
// Number of arbitration bits and index of the last one.
`define ARB_BITS          4'hA
`define ARB_LAST          4'h9
// Reserved priority values and the all-ones node identity.
`define PRIO_FAIR         4'h0
`define PRIO_ONES         4'hF
`define PRIO_CLIP         4'hE
`define NODE_ONES         6'h3F
`define CODE_ZERO         10'h000
`define CNT_ZERO          4'h0
`define CNT_ONE           4'h1
// Edges the strap samplers need after a reset before their last stage holds the pins.
`define LOAD_SETTLE       2'h3
`define WAIT_ZERO         2'h0
`define WAIT_ONE          2'h1
`endif

// ### rtl/arb_pkg.sv
// Types shared by the backplane arbitration design files.
// Assumes arb_consts.svh is on the include path.
package arb_pkg;
  `include "arb_consts.svh"

  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_SEND} arb_state_type;

  typedef struct packed {
    logic [3:0] priority_code;
    logic [5:0] node_identity;
  } arb_code_type;

  typedef struct packed {
    arb_state_type state;
    logic [3:0]    tick_cnt;
    logic [3:0]    bit_cnt;
    logic [9:0]    shift_code;
    logic [9:0]    seen_code;
    logic          contending;
    logic          drive_bit;
    logic          won;
    logic          lost;
    logic          link_clk;
    logic          load_pending;
    logic [1:0]    load_wait;
    arb_code_type  own_code;
    arb_code_type  winner_code;
    arb_code_type  strap_s1;
    arb_code_type  strap_s2;
    arb_code_type  strap_s3;
    logic          line_s1;
    logic          line_s2;
    logic          line_s3;
    logic          line_stable;
  } arb_regs_type;

  typedef struct packed {
    logic data;
    logic strobe;
  } ds_regs_type;
endpackage

// ### rtl/ds_encoder.sv
// Data-strobe line encoder for the packet phase after a won arbitration.
// Assumes bit_take is a one-cycle pulse at most once per bit period.
`timescale 1ns/1ps
`include "arb_consts.svh"
module ds_encoder (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic bit_take,
  input  wire logic bit_data,
  output logic      ds_data_out,
  output logic      ds_strobe_out
);
  arb_pkg::ds_regs_type ds_reg;
  arb_pkg::ds_regs_type ds_next;

  // --------------------------------------------------------------
  // Encoder
  // --------------------------------------------------------------
  // Exactly one line changes per bit, so neither line runs faster than half the bit rate.
  always_comb
  begin
    ds_next = ds_reg;
    if (bit_take)
    begin
      ds_next.data = bit_data;
      if (bit_data == ds_reg.data)
      begin
        ds_next.strobe = ~ds_reg.strobe;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ds_reg <= '0;
    end
    else
    begin
      ds_reg <= ds_next;
    end
  end

  assign ds_data_out   = ds_reg.data;
  assign ds_strobe_out = ds_reg.strobe;

  chk_ds_one_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
    bit_take |=> ((ds_reg.data != $past(ds_reg.data)) != (ds_reg.strobe != $past(ds_reg.strobe))))
    else $error("Data-strobe pair did not change exactly one line.");
endmodule

// ### rtl/backplane_serial_arbitration.sv
// Bit-serial backplane arbitration: priority then node number, read back per bit.
// Assumes a shared wired-OR line where a driven 1 dominates and released reads 0.
// Operation
// - While contending the node shifts out its priority and then its node number, one bit per bit period.
// - Each bit period the line is sampled and the node drops out when it differs from the driven bit.
// - A node that drives a 1 and reads it back stays, and a node driving 0 that reads 1 withdraws.
// - Bits go out from the priority MSB down to its LSB, followed directly by the node number MSB.
// - Priority zero marks fair arbitration and all ones is kept for the cycle start packet.
// - Hardware reset or a software hard reset reloads the 4-bit priority and 6-bit identity from the straps.
// - Software may rewrite both values after reset, and they hold until the next reset.
// - All timing derives from the local reference clock by internal division.
// - Packet bits leave on a data and strobe pair so each line toggles at most at half the bit rate.
// - The link-side clock is the reference divided by two and launches on its rising edge.
// - The winner's identity and priority are recorded and a robust bus reset sets both to all ones.
`timescale 1ns/1ps
`include "arb_consts.svh"
module backplane_serial_arbitration (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                software_hard_reset_request,
  input  wire logic [3:0]          strap_priority_pins,
  input  wire logic [5:0]          strap_node_identity_pins,
  input  wire logic                sw_code_write,
  input  wire arb_pkg::arb_code_type sw_code,
  input  wire logic                arb_request,
  input  wire logic                cycle_start_request,
  input  wire logic                arb_opportunity,
  input  wire logic                robust_bus_reset,
  input  wire logic                arb_line_in,
  output logic                     arb_line_out,
  output logic                     arb_line_oe_n,
  input  wire logic                tx_bit_valid,
  input  wire logic                tx_bit_data,
  input  wire logic                tx_bit_last,
  output logic                     tx_bit_ready,
  output logic                     ds_data_out,
  output logic                     ds_strobe_out,
  output logic                     link_clk_out,
  output logic                     arb_won,
  output logic                     arb_lost,
  output logic                     arb_busy,
  output logic                     fair_mode,
  output arb_pkg::arb_code_type    own_code,
  output arb_pkg::arb_code_type    winner_code
);
  arb_pkg::arb_regs_type r_reg;
  arb_pkg::arb_regs_type r_next;
  logic                  tick_last;
  logic                  bit_take;
  logic [3:0]            start_prio;

  // --------------------------------------------------------------
  // Timing and handshake terms
  // --------------------------------------------------------------
  // The bit period is a fixed division of the reference clock.
  assign tick_last    = (r_reg.tick_cnt == `BIT_LAST);
  assign tx_bit_ready = (r_reg.state == arb_pkg::ST_SEND) && tick_last;
  assign bit_take     = tx_bit_ready && tx_bit_valid;

  // Normal traffic may not use the cycle start level, so it is clipped one below.
  always_comb
  begin
    if (cycle_start_request)
    begin
      start_prio = `PRIO_ONES;
    end
    else if (r_reg.own_code.priority_code == `PRIO_ONES)
    begin
      start_prio = `PRIO_CLIP;
    end
    else
    begin
      start_prio = r_reg.own_code.priority_code;
    end
  end

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  // One pass computes every register of the block.
  always_comb
  begin
    r_next          = r_reg;
    r_next.won      = 1'b0;
    r_next.lost     = 1'b0;
    r_next.link_clk = ~r_reg.link_clk;

    // Three-stage pin sampling; a change counts once stages two and three agree.
    r_next.line_s1 = arb_line_in;
    r_next.line_s2 = r_reg.line_s1;
    r_next.line_s3 = r_reg.line_s2;
    if (r_reg.line_s2 == r_reg.line_s3)
    begin
      r_next.line_stable = r_reg.line_s3;
    end
    r_next.strap_s1 = {strap_priority_pins, strap_node_identity_pins};
    r_next.strap_s2 = r_reg.strap_s1;
    r_next.strap_s3 = r_reg.strap_s2;

    // Straps are taken only after the samplers settle, never inside reset itself.
    // Reset clears the sampler stages, so their agreement means nothing until they have refilled.
    if (software_hard_reset_request)
    begin
      r_next.load_pending = 1'b1;
      r_next.load_wait    = `WAIT_ZERO;
    end
    else if (r_reg.load_pending && (r_reg.load_wait != `LOAD_SETTLE))
    begin
      r_next.load_wait = r_reg.load_wait + `WAIT_ONE;
    end
    else if (r_reg.load_pending && (r_reg.strap_s2 == r_reg.strap_s3))
    begin
      r_next.own_code     = r_reg.strap_s3;
      r_next.load_pending = 1'b0;
    end
    else if (sw_code_write && !r_reg.load_pending)
    begin
      r_next.own_code = sw_code;
    end

    if (r_reg.state == arb_pkg::ST_IDLE)
    begin
      r_next.tick_cnt = `CNT_ZERO;
    end
    else if (tick_last)
    begin
      r_next.tick_cnt = `CNT_ZERO;
    end
    else
    begin
      r_next.tick_cnt = r_reg.tick_cnt + `CNT_ONE;
    end

    case (r_reg.state)
      arb_pkg::ST_IDLE:
      begin
        if (arb_opportunity)
        begin
          r_next.state      = arb_pkg::ST_ARB;
          r_next.bit_cnt    = `CNT_ZERO;
          r_next.contending = arb_request;
          r_next.shift_code = {start_prio, r_reg.own_code.node_identity};
          r_next.drive_bit  = arb_request && start_prio[3];
          r_next.seen_code  = `CODE_ZERO;
        end
      end
      arb_pkg::ST_ARB:
      begin
        if (tick_last)
        begin
          r_next.seen_code = {r_reg.seen_code[8:0], r_reg.line_stable};
          r_next.bit_cnt   = r_reg.bit_cnt + `CNT_ONE;
          // Driving 0 and reading 1 means a higher code is on the line.
          if (r_reg.contending && (r_reg.line_stable != r_reg.drive_bit))
          begin
            r_next.contending = 1'b0;
            r_next.lost       = 1'b1;
          end
          r_next.shift_code = {r_reg.shift_code[8:0], 1'b0};
          r_next.drive_bit  = r_next.contending && r_reg.shift_code[8];
          if (r_reg.bit_cnt == `ARB_LAST)
          begin
            // The wired-OR line spells out the winner's code bit for bit.
            r_next.winner_code = {r_reg.seen_code[8:0], r_reg.line_stable};
            r_next.drive_bit   = 1'b0;
            if (r_next.contending)
            begin
              r_next.state = arb_pkg::ST_SEND;
              r_next.won   = 1'b1;
            end
            else
            begin
              r_next.state = arb_pkg::ST_IDLE;
            end
          end
        end
      end
      arb_pkg::ST_SEND:
      begin
        if (bit_take && tx_bit_last)
        begin
          r_next.state = arb_pkg::ST_IDLE;
        end
      end
      default:
      begin
        r_next.state = arb_pkg::ST_IDLE;
      end
    endcase

    // A bus reset landing with a win still leaves the winner fields at ones.
    if (robust_bus_reset)
    begin
      r_next.winner_code = {`PRIO_ONES, `NODE_ONES};
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset forces constants; the strap load follows once sampling settles.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      r_reg              <= '0;
      r_reg.state        <= arb_pkg::ST_IDLE;
      r_reg.load_pending <= 1'b1;
      r_reg.winner_code  <= {`PRIO_ONES, `NODE_ONES};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  ds_encoder i_ds_encoder (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .bit_take      (bit_take),
    .bit_data      (tx_bit_data),
    .ds_data_out   (ds_data_out),
    .ds_strobe_out (ds_strobe_out)
  );

  // Only a driven 1 enables the driver; a 0 is a released line.
  assign arb_line_out  = r_reg.drive_bit;
  assign arb_line_oe_n = ~r_reg.drive_bit;
  assign link_clk_out  = r_reg.link_clk;
  assign arb_won       = r_reg.won;
  assign arb_lost      = r_reg.lost;
  assign arb_busy      = (r_reg.state != arb_pkg::ST_IDLE);
  assign fair_mode     = (r_reg.own_code.priority_code == `PRIO_FAIR);
  assign own_code      = r_reg.own_code;
  assign winner_code   = r_reg.winner_code;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence seq_arb_start;
    (r_reg.state == arb_pkg::ST_IDLE) && arb_opportunity && arb_request;
  endsequence

  sequence seq_mismatch;
    (r_reg.state == arb_pkg::ST_ARB) && tick_last && r_reg.contending && (r_reg.line_stable != r_reg.drive_bit);
  endsequence

  chk_msb_first_out: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_arb_start |=> (r_reg.drive_bit == $past(start_prio[3])))
    else $error("First arbitration bit is not the priority MSB.");
  chk_bit_held: assert property (@(posedge mclk) disable iff (sys_rst)
    ((r_reg.state == arb_pkg::ST_ARB) && !tick_last) |=> $stable(r_reg.drive_bit))
    else $error("Arbitration bit changed inside its bit period.");
  chk_mismatch_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_mismatch |=> (!r_reg.contending && r_reg.lost))
    else $error("Node stayed in contention after a mismatch.");
  chk_loser_released: assert property (@(posedge mclk) disable iff (sys_rst)
    !r_reg.contending |-> (arb_line_oe_n && !r_reg.won))
    else $error("Node drives the line after losing.");
  chk_win_sends: assert property (@(posedge mclk) disable iff (sys_rst)
    r_reg.won |-> ((r_reg.state == arb_pkg::ST_SEND) && (r_reg.bit_cnt == `ARB_BITS) && r_reg.contending))
    else $error("Win without ten matched bits.");
  chk_ones_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    (seq_arb_start ##0 !cycle_start_request) |=> (r_reg.shift_code[9:6] != `PRIO_ONES))
    else $error("All-ones priority used outside cycle start.");
  chk_strap_load: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(r_reg.load_pending) |-> (r_reg.own_code == $past(r_reg.strap_s3)))
    else $error("Strap values not loaded on reset.");
  chk_sw_override: assert property (@(posedge mclk) disable iff (sys_rst)
    (sw_code_write && !r_reg.load_pending && !software_hard_reset_request) |=> (own_code == $past(sw_code)))
    else $error("Software code write not taken.");
  chk_winner_ones: assert property (@(posedge mclk) disable iff (sys_rst)
    robust_bus_reset |=> (winner_code == {`PRIO_ONES, `NODE_ONES}))
    else $error("Winner fields not all ones after bus reset.");
  chk_link_clk_div: assert property (@(posedge mclk) disable iff (sys_rst)
    link_clk_out |=> !link_clk_out ##1 link_clk_out)
    else $error("Link clock is not the reference divided by two.");
endmodule

// ### testbench/rival_node.sv
// Behavioural model of one rival node sharing the wired-OR arbitration line.
// Assumes start is the same opportunity pulse the design sees and line is the resolved wire.
`timescale 1ns/1ps
module rival_node (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       enable,
  input  wire logic [9:0] code,
  input  wire logic       line,
  output logic            drive
);
  logic [3:0] tick;
  logic [3:0] idx;
  logic       active;

  // Eight cycles a bit, MSB first; a mismatch at the sample point drops the node out.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      active <= 1'b0;
    else if (start && enable && !active)
    begin
      active <= 1'b1;
      tick   <= 4'h0;
      idx    <= 4'h0;
    end
    else if (active)
    begin
      tick <= tick + 4'h1;
      if (tick == 4'h7)
      begin
        tick <= 4'h0;
        idx  <= idx + 4'h1;
        if (line !== code[4'h9 - idx] || idx == 4'h9)
          active <= 1'b0;
      end
    end
  end

  // A released node drives 0, which the pull-down wire reads as released.
  assign drive = active & code[4'h9 - idx];
endmodule

// ### testbench/backplane_serial_arbitration_tb_top.sv
// Self-checking bench for the backplane arbitration block against one rival node.
// Assumes the wired-OR line reads 0 when released and a driven 1 dominates.
`timescale 1ns/1ps
module backplane_serial_arbitration_tb_top;
  typedef struct packed {
    logic [9:0] own;
    logic [9:0] rival;
    logic       req;
    logic       cs;
    logic       ren;
  } row_type;
  localparam row_type ROWS [7] = '{'{10'h14A, 10'h0FF, 1'h1, 1'h0, 1'h1}, '{10'h081, 10'h082, 1'h1, 1'h0, 1'h1},
    '{10'h030, 10'h02F, 1'h1, 1'h0, 1'h1}, '{10'h3C1, 10'h382, 1'h1, 1'h0, 1'h1},
    '{10'h3C1, 10'h382, 1'h1, 1'h1, 1'h1}, '{10'h155, 10'h000, 1'h1, 1'h0, 1'h0},
    '{10'h155, 10'h0AA, 1'h0, 1'h0, 1'h1}};
  logic                  mclk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  hard_rst = 1'b0;
  logic [3:0]            strap_prio = 4'h3;
  logic [5:0]            strap_node = 6'h15;
  logic                  sw_code_write = 1'b0;
  arb_pkg::arb_code_type sw_code = 10'h000;
  logic                  arb_request = 1'b0;
  logic                  cycle_start_request = 1'b0;
  logic                  arb_opportunity = 1'b0;
  logic                  robust_bus_reset = 1'b0;
  logic                  tx_bit_valid = 1'b0;
  logic                  tx_bit_data = 1'b0;
  logic                  tx_bit_last = 1'b0;
  logic                  rival_en = 1'b0;
  logic [9:0]            rival_code = 10'h000;
  logic                  rival_drive;
  logic                  arb_line;
  logic                  arb_line_out, arb_line_oe_n, tx_bit_ready, ds_data_out, ds_strobe_out;
  logic                  link_clk_out, arb_won, arb_lost, arb_busy, fair_mode;
  arb_pkg::arb_code_type own_code, winner_code;
  logic                  exp_d = 1'b0;
  logic                  exp_s = 1'b0;
  logic                  prev_lc;
  int                    err_count = 0;
  int                    samples_checked = 0;

  // Reference clock at 100 MHz.
  always #5 mclk = ~mclk;

  // Wired-OR resolution: the design only pulls the line while its enable is low.
  assign arb_line = (~arb_line_oe_n & arb_line_out) | rival_drive;

  backplane_serial_arbitration i_backplane_serial_arbitration (.mclk(mclk), .sys_rst(sys_rst),
    .software_hard_reset_request(hard_rst), .strap_priority_pins(strap_prio),
    .strap_node_identity_pins(strap_node), .sw_code_write(sw_code_write), .sw_code(sw_code),
    .arb_request(arb_request), .cycle_start_request(cycle_start_request), .arb_opportunity(arb_opportunity),
    .robust_bus_reset(robust_bus_reset), .arb_line_in(arb_line), .arb_line_out(arb_line_out),
    .arb_line_oe_n(arb_line_oe_n), .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data),
    .tx_bit_last(tx_bit_last), .tx_bit_ready(tx_bit_ready), .ds_data_out(ds_data_out),
    .ds_strobe_out(ds_strobe_out), .link_clk_out(link_clk_out), .arb_won(arb_won), .arb_lost(arb_lost),
    .arb_busy(arb_busy), .fair_mode(fair_mode), .own_code(own_code), .winner_code(winner_code));

  rival_node i_rival_node (.mclk(mclk), .sys_rst(sys_rst), .start(arb_opportunity), .enable(rival_en),
    .code(rival_code), .line(arb_line), .drive(rival_drive));

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Sends bits 0,1,1 after a win; the strobe toggles whenever data repeats.
  task automatic send_packet;
    int w;
    for (int b = 0; b < 3; b++)
    begin
      tx_bit_valid = 1'b1;
      tx_bit_data = (b != 0);
      tx_bit_last = (b == 2);
      w = 0;
      while (tx_bit_ready !== 1'b1 && w < 20)
      begin
        @(negedge mclk);
        w++;
      end
      repeat (2) @(negedge mclk);
      if (tx_bit_data == exp_d)
        exp_s = ~exp_s;
      exp_d = tx_bit_data;
      check(ds_data_out === exp_d && ds_strobe_out === exp_s, "data strobe pair");
    end
    tx_bit_valid = 1'b0;
    tx_bit_last = 1'b0;
  endtask

  // One arbitration window; the expected winner is the larger code as actually sent.
  task automatic run_row(input row_type r);
    logic [9:0] eff;
    logic       exp_win;
    logic       quiet;
    int         cnt;
    int         k;
    eff = r.own;
    if (r.own[9:6] == 4'hF && !r.cs)
      eff[9:6] = 4'hE;
    exp_win = !r.ren || eff > r.rival;
    k = 10;
    for (int i = 0; i < 10; i++)
      if (r.ren && k == 10 && eff[9-i] != r.rival[9-i])
        k = i + 1;
    // A winner only learns of its win after all ten bits.
    if (exp_win)
      k = 10;
    sw_code = r.own;
    sw_code_write = 1'b1;
    @(negedge mclk);
    sw_code_write = 1'b0;
    arb_request = r.req;
    cycle_start_request = r.cs;
    rival_code = r.rival;
    rival_en = r.ren;
    check(own_code === r.own, "own code after write");
    check(fair_mode === (r.own[9:6] == 4'h0), "fair flag");
    arb_opportunity = 1'b1;
    @(negedge mclk);
    arb_opportunity = 1'b0;
    cnt = 0;
    quiet = 1'b1;
    while (cnt < 100 && arb_won !== 1'b1 && arb_lost !== 1'b1)
    begin
      @(negedge mclk);
      cnt++;
      if (!r.req && arb_line_oe_n !== 1'b1)
        quiet = 1'b0;
    end
    if (r.req)
    begin
      check(arb_won === exp_win && arb_lost === !exp_win, "win or loss");
      check(cnt == 8 * k || cnt == 8 * k + 1, "bit at which outcome came");
    end
    if (r.req && exp_win)
      send_packet();
    cnt = 0;
    while (cnt < 100 && arb_busy !== 1'b0)
    begin
      @(negedge mclk);
      cnt++;
      if (!exp_win && arb_line_oe_n !== 1'b1)
        quiet = 1'b0;
    end
    check(quiet === 1'b1 && arb_busy === 1'b0, "line released when not winning");
    check(winner_code === (r.req && exp_win ? eff : r.rival), "winner record");
  endtask

  initial
  begin
    repeat (3) @(negedge mclk);
    check(winner_code === 10'h3FF && arb_line_oe_n === 1'b1, "reset values");
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (6) @(negedge mclk);
    check(own_code === {strap_prio, strap_node}, "strap load");
    for (int c = 0; c < 4; c++)
    begin
      prev_lc = link_clk_out;
      @(negedge mclk);
      check(link_clk_out === ~prev_lc, "link clock toggles each cycle");
    end
    $display("reset test done");
    for (int i = 0; i < 7; i++)
    begin
      run_row(ROWS[i]);
      $display("row %0d done", i);
    end
    robust_bus_reset = 1'b1;
    @(negedge mclk);
    robust_bus_reset = 1'b0;
    @(negedge mclk);
    check(winner_code === 10'h3FF, "robust bus reset");
    $display("bus reset test done");
    strap_prio = 4'h9;
    strap_node = 6'h2C;
    repeat (4) @(negedge mclk);
    hard_rst = 1'b1;
    sw_code_write = 1'b1;
    sw_code = 10'h111;
    @(negedge mclk);
    hard_rst = 1'b0;
    sw_code_write = 1'b0;
    repeat (6) @(negedge mclk);
    check(own_code === {strap_prio, strap_node}, "hard reset reload");
    $display("hard reset test done");
    summarize();
  end

  // Link clock is the reference halved: it must differ on every consecutive cycle.
  initial
  begin
    logic prev;
    wait (sys_rst == 1'b0);
    repeat (3) @(negedge mclk);
    prev = link_clk_out;
    for (int c = 0; c < 6; c++)
    begin
      @(negedge mclk);
      check(link_clk_out === ~prev, "link clock halves the reference");
      prev = link_clk_out;
    end
  end

  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
